// ---- hw/timer_pkg.sv ----
// Function
// [RL1] Three independent counters, each with a 16-bit count set by software.
// [RL2] Each counter counts in binary or BCD, chosen separately per counter.
// [RL3] A command picks one of seven functions per counter; counters run independently.
// [RL4] Terminal-count function raises an interrupt request on the output at terminal count.
// [RL5] One-shot drops output on trigger edge or software command, rises at terminal count, retriggerable.
// [RL6] Rate generator divides by N: one clock low pulse every N input clocks.
// [RL7] Square wave is high for the first half of the count, low for the second; in BCD the code halves the count in binary, so the split is uneven.
// [RL8] Software strobe: output high until load, then one low period N counts later.
// [RL9] Hardware strobe: one low period N counts after a trigger rise; retriggerable.
// [RL10] Event counter counts external events; readable, or interrupt after N events.
// [RL11] Counts readable anytime; a latch command captures a count without disturbing it.
// [RL12] The third counter is the bit-rate divider for the serial port.
// [RL13] First two outputs route independently to interrupts, line drivers or parallel inputs.
// [RL14] First two gates come from line terminators or parallel-port outputs, as configured.
// [RL15] Counters decrement once per input clock edge while gated; zero is terminal count; the code stops counting there except in rate and square modes.
package timer_pkg;

  localparam int          NUM_CH      = 3;
  localparam int          CNT_W       = 16;
  localparam int          ROUTED_CH   = 2;
  localparam int          BAUD_CH     = 2;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [15:0] BIN_MAX     = 16'hFFFF;
  localparam logic [15:0] BCD_MAX     = 16'h9999;
  localparam logic [3:0]  BCD_NINE    = 4'h9;
  localparam logic        OUT_RESET   = 1'b1;

  typedef enum logic [2:0] {
    FN_TC_IRQ    = 3'h0,
    FN_ONE_SHOT  = 3'h1,
    FN_RATE      = 3'h2,
    FN_SQUARE    = 3'h3,
    FN_SW_STROBE = 3'h4,
    FN_HW_STROBE = 3'h5,
    FN_EVENT     = 3'h6
  } func_type;

  // Decimal decrement borrows digit by digit; zero wraps to the top of the range
  function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - COUNT_ONE;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (v[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = BCD_NINE;
          end else begin
            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : dec_count

endpackage : timer_pkg

// ---- hw/sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : sync_if
`default_nettype wire

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic raw,
  sync_if.src      so
);
  logic meta;
  logic stage;
  logic prev;

  // Only the second stage and its delayed copy feed the edge detector
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta  <= 1'b0;
      stage <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= raw;
      stage <= meta;
      prev  <= stage;
    end
  end

  assign so.level = stage;
  assign so.rise  = stage & ~prev;
endmodule : pin_sync
`default_nettype wire

// ---- hw/interval_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module interval_timer
  import timer_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_we,
  input  wire logic [1:0]  cfg_sel,
  input  wire logic [2:0]  cfg_func,
  input  wire logic        cfg_bcd,
  input  wire logic        load_we,
  input  wire logic [1:0]  load_sel,
  input  wire logic [15:0] load_value,
  input  wire logic        latch_req,
  input  wire logic [1:0]  latch_sel,
  input  wire logic        sw_trigger,
  input  wire logic [1:0]  trig_sel,
  input  wire logic [2:0]  cnt_clk_pin,
  input  wire logic [2:0]  event_pin,
  input  wire logic [1:0]  gate_pin,
  input  wire logic [1:0]  gate_pp,
  input  wire logic [1:0]  gate_src_sel,
  input  wire logic [1:0]  route_irq_en,
  input  wire logic [1:0]  route_drv_en,
  input  wire logic [1:0]  route_ppin_en,
  output logic [47:0]      count_now,
  output logic [15:0]      latched_value,
  output logic             latched_valid,
  output logic [2:0]       timer_out,
  output logic [1:0]       irq_req,
  output logic [1:0]       pp_drive,
  output logic [1:0]       pp_in,
  output logic             baud_clk
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  sync_if clk_s [NUM_CH] ();
  sync_if evt_s [NUM_CH] ();
  sync_if gate_s [ROUTED_CH] ();

  logic [15:0] count_w  [NUM_CH];
  logic [15:0] reload_w [NUM_CH];
  logic [15:0] dec_w    [NUM_CH];
  func_type    func_w   [NUM_CH];
  logic        bcd_w    [NUM_CH];
  logic        run_w    [NUM_CH];
  logic        out_w    [NUM_CH];
  logic        ce_w     [NUM_CH];
  logic        trig_w   [NUM_CH];
  logic        tick_w   [NUM_CH];
  logic        cfg_hit_w  [NUM_CH];
  logic        load_hit_w [NUM_CH];
  logic [2:0]  gate_lvl;
  logic [2:0]  gate_rise;
  logic [1:0]  gate_mux;
  logic [1:0]  gate_prev;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pins
      pin_sync u_clk (.ref_clk(ref_clk), .rst_n(rst_n), .raw(cnt_clk_pin[g]), .so(clk_s[g]));
      pin_sync u_evt (.ref_clk(ref_clk), .rst_n(rst_n), .raw(event_pin[g]), .so(evt_s[g]));
      assign tick_w[g] = (func_w[g] == FN_EVENT) ? evt_s[g].rise : clk_s[g].rise; // [RL10]
    end
    for (g = 0; g < ROUTED_CH; g++) begin : g_gates
      pin_sync u_gate (.ref_clk(ref_clk), .rst_n(rst_n), .raw(gate_pin[g]), .so(gate_s[g]));
      // Parallel-port outputs share this clock, so they need no synchroniser
      assign gate_mux[g] = gate_src_sel[g] ? gate_pp[g] : gate_s[g].level; // [RL14]
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_prev <= 2'h0;
    end else begin
      gate_prev <= gate_mux;
    end
  end

  // The baud divider has no gate pin: its gate stands open and gives no trigger edge
  assign gate_lvl  = {1'b1, gate_mux};
  assign gate_rise = {1'b0, gate_mux & ~gate_prev};

  ////////////////////////////////////////////////////////////////////////////
  // Counter channels

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [15:0] count;
      logic [15:0] reload;
      func_type    func;
      logic        bcd;
      logic        run;
      logic        out;
      logic        level_gated;
      logic        edge_trig;
      logic        at_one;
      logic        sq_high;
      logic [15:0] next_count;

      assign cfg_hit_w[g]  = cfg_we && (cfg_sel == 2'(g));
      assign load_hit_w[g] = load_we && (load_sel == 2'(g));
      assign level_gated   = (func != FN_ONE_SHOT) && (func != FN_HW_STROBE);
      assign edge_trig     = (func == FN_ONE_SHOT) && sw_trigger && (trig_sel == 2'(g));
      assign trig_w[g]     = !level_gated && (gate_rise[g] || edge_trig); // [RL5] [RL9]
      assign ce_w[g]       = run && tick_w[g] && (!level_gated || gate_lvl[g]); // [RL15]
      assign dec_w[g]      = dec_count(count, bcd); // [RL2]
      assign at_one        = (count == COUNT_ONE);
      assign next_count    = at_one ? reload : dec_w[g];
      // Halving is binary, so a BCD square wave splits unevenly
      assign sq_high       = next_count > (reload >> 1);

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          count  <= COUNT_RESET;
          reload <= COUNT_RESET;
          func   <= FN_TC_IRQ;
          bcd    <= 1'b0;
          run    <= 1'b0;
          out    <= OUT_RESET;
        end else if (cfg_hit_w[g]) begin
          func <= func_type'(cfg_func); // [RL3]
          bcd  <= cfg_bcd; // [RL2]
          run  <= 1'b0;
          out  <= (cfg_func == FN_TC_IRQ || cfg_func == FN_EVENT) ? 1'b0 : 1'b1;
        end else if (load_hit_w[g]) begin
          reload <= load_value; // [RL1]
          count  <= load_value;
          run    <= level_gated; // [RL8]
          out    <= (func == FN_TC_IRQ || func == FN_EVENT) ? 1'b0 : 1'b1;
        end else if (trig_w[g]) begin
          count <= reload; // [RL5] [RL9]
          run   <= 1'b1;
          out   <= (func != FN_ONE_SHOT);
        end else if (ce_w[g]) begin
          unique case (func)
            FN_TC_IRQ, FN_EVENT, FN_ONE_SHOT: begin
              count <= dec_w[g]; // [RL15]
              if (at_one) begin
                out <= 1'b1; // [RL4] [RL10]
                run <= 1'b0;
              end
            end
            FN_RATE: begin
              count <= next_count;
              out   <= !at_one; // [RL6]
            end
            FN_SQUARE: begin
              count <= next_count;
              out   <= sq_high; // [RL7]
            end
            FN_SW_STROBE, FN_HW_STROBE: begin
              if (!out) begin
                out <= 1'b1;
                run <= 1'b0;
              end else begin
                count <= dec_w[g];
                out   <= !at_one; // [RL8] [RL9]
              end
            end
            default: begin
              run <= 1'b0;
            end
          endcase
        end
      end

      assign count_w[g]  = count;
      assign reload_w[g] = reload;
      assign func_w[g]   = func;
      assign bcd_w[g]    = bcd;
      assign run_w[g]    = run;
      assign out_w[g]    = out;
      assign count_now[g*16 +: 16] = count; // [RL11]
      assign timer_out[g]          = out;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Latch read and output routing

  logic [15:0] latch_pick;
  assign latch_pick = (latch_sel == 2'h0) ? count_w[0] :
                      (latch_sel == 2'h1) ? count_w[1] :
                      (latch_sel == 2'h2) ? count_w[2] : COUNT_RESET;

  logic [1:0] next_irq;
  logic [1:0] next_drv;
  logic [1:0] next_ppin;
  assign next_irq  = {out_w[1], out_w[0]} & route_irq_en; // [RL13]
  assign next_drv  = {out_w[1], out_w[0]} & route_drv_en;
  assign next_ppin = {out_w[1], out_w[0]} & route_ppin_en;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_value <= COUNT_RESET;
      latched_valid <= 1'b0;
      irq_req       <= 2'h0;
      pp_drive      <= 2'h0;
      pp_in         <= 2'h0;
      baud_clk      <= OUT_RESET;
    end else begin
      latched_valid <= latch_req; // [RL11]
      if (latch_req) begin
        latched_value <= latch_pick;
      end
      irq_req  <= next_irq;
      pp_drive <= next_drv;
      pp_in    <= next_ppin;
      baud_clk <= out_w[BAUD_CH]; // [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  latch_capture_a: assert property ( // [RL11]
    latch_req && latch_sel == 2'h0 |=> latched_valid && latched_value == $past(count_w[0]))
    else $error("latched value does not match counter 0");

  // A command at the same edge as a tick wins, so the step checks skip those edges
  logic [1:0] cmd_free;
  assign cmd_free[0] = !cfg_hit_w[0] && !load_hit_w[0];
  assign cmd_free[1] = !cfg_hit_w[1] && !load_hit_w[1];

  count_step_a: assert property ( // [RL15]
    ce_w[0] && func_w[0] == FN_TC_IRQ && !bcd_w[0] && cmd_free[0]
      |=> count_w[0] == $past(count_w[0]) - 16'h0001)
    else $error("counter 0 did not step down by one");

  tc_irq_a: assert property ( // [RL4]
    ce_w[0] && func_w[0] == FN_TC_IRQ && count_w[0] == 16'h0001 && cmd_free[0]
      |=> out_w[0] && !run_w[0] ##1 out_w[0])
    else $error("terminal count did not raise the request");

  rate_pulse_a: assert property ( // [RL6]
    ce_w[0] && func_w[0] == FN_RATE && count_w[0] == 16'h0001 && cmd_free[0]
      |=> !out_w[0] && count_w[0] == reload_w[0])
    else $error("rate generator pulse or reload wrong");

  oneshot_low_a: assert property ( // [RL5]
    trig_w[1] && func_w[1] == FN_ONE_SHOT && cmd_free[1]
      |=> !out_w[1] && run_w[1] && count_w[1] == reload_w[1])
    else $error("one-shot trigger did not start the shot");

  square_wrap_a: assert property ( // [RL7]
    ce_w[1] && func_w[1] == FN_SQUARE && count_w[1] == 16'h0001 && cmd_free[1]
      |=> out_w[1] && count_w[1] == reload_w[1])
    else $error("square wave did not restart high");

  strobe_end_a: assert property ( // [RL8]
    ce_w[0] && func_w[0] == FN_SW_STROBE && !out_w[0] && cmd_free[0] |=> out_w[0] && !run_w[0])
    else $error("strobe pulse longer than one period");

  bcd_digit_a: assert property ( // [RL2]
    ce_w[0] && bcd_w[0] && func_w[0] == FN_RATE && count_w[0] == 16'h0010 && cmd_free[0]
      |=> count_w[0] == 16'h0009)
    else $error("decimal borrow wrong");

  event_tick_a: assert property ( // [RL10]
    evt_s[1].rise && run_w[1] && gate_lvl[1] && func_w[1] == FN_EVENT && !bcd_w[1] && cmd_free[1]
      |=> count_w[1] == $past(count_w[1]) - 16'h0001)
    else $error("event was not counted");

  event_done_a: assert property ( // [RL10]
    ce_w[1] && func_w[1] == FN_EVENT && count_w[1] == 16'h0001 && cmd_free[1]
      |=> out_w[1] && !run_w[1])
    else $error("no request after the last event");

  strobe_pulse_a: assert property ( // [RL9]
    ce_w[1] && func_w[1] == FN_HW_STROBE && out_w[1] && count_w[1] == 16'h0001 && cmd_free[1] && !trig_w[1]
      |=> !out_w[1])
    else $error("hardware strobe pulse missing");

  gate_hold_a: assert property ( // [RL15]
    !gate_lvl[0] && func_w[0] == FN_RATE && cmd_free[0]
      |=> count_w[0] == $past(count_w[0]) && out_w[0] == $past(out_w[0]))
    else $error("closed gate did not hold counter 0");

  latch_pulse_a: assert property ( // [RL11]
    !latch_req |=> !latched_valid)
    else $error("latch valid stood longer than one cycle");

  baud_follow_a: assert property ( // [RL12]
    $changed(out_w[BAUD_CH]) |=> baud_clk == $past(out_w[BAUD_CH]))
    else $error("bit-rate clock does not follow counter 2");

  route_irq_a: assert property ( // [RL13]
    out_w[0] && route_irq_en[0] |=> irq_req[0])
    else $error("routed interrupt missing");

  cfg_take_a: assert property ( // [RL3]
    cfg_hit_w[1] && cfg_func != 3'h7 |=> func_w[1] == $past(cfg_func) && !run_w[1])
    else $error("function command not taken");

  rate_seen_c: cover property (ce_w[0] && func_w[0] == FN_RATE && count_w[0] == 16'h0001);
  shot_retrig_c: cover property (trig_w[1] && func_w[1] == FN_ONE_SHOT && !out_w[1]);
  hw_strobe_c: cover property (func_w[1] == FN_HW_STROBE && $fell(out_w[1]));
  latch_run_c: cover property (latch_req && run_w[latch_sel == 2'h1 ? 1 : 0]);

endmodule : interval_timer
`default_nettype wire

// ---- sim/pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [2:0] evt_go,
  output logic [2:0]      clk_pins,
  output logic [2:0]      evt_pins
);
  logic [2:0] phase;
  logic [1:0] hold;
  logic [2:0] mask;
  initial begin
    phase = 3'h0;
    hold  = 2'h0;
    mask  = 3'h0;
  end
  // Input clocks stand low while stopped, so no stray edge reaches the counters
  // Requests from the bench change at the falling edge, so they are taken at the rising one
  always @(posedge ref_clk) begin
    phase <= run ? phase + 3'h1 : 3'h0;
  end
  assign clk_pins = {3{phase[2]}};
  // Pulses last three cycles so the two-stage synchroniser cannot miss them
  always @(posedge ref_clk) begin
    if (|evt_go) begin
      mask <= evt_go;
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
  assign evt_pins = (hold != 2'h0) ? mask : 3'h0;
endmodule : pin_model
`default_nettype wire

// ---- sim/interval_timer_event_counter_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module interval_timer_event_counter_test
  import timer_pkg::*;
;
  typedef struct {
    int          ch;
    func_type    fn;
    logic        bcd;
    logic [15:0] n;
    int          low;
    int          per;
    logic        trig;
  } row_type;
  logic        ref_clk, rst_n, cfg_we, cfg_bcd, load_we, latch_req, sw_trigger, run;
  logic [1:0]  cfg_sel, load_sel, latch_sel, trig_sel, gate_pin, gate_pp, gate_src_sel;
  logic [1:0]  route_irq_en, route_drv_en, route_ppin_en, irq_req, pp_drive, pp_in;
  logic [2:0]  cfg_func, cnt_clk_pin, event_pin, evt_go, timer_out;
  logic [15:0] load_value, latched_value;
  logic [47:0] count_now;
  logic        latched_valid, baud_clk;
  int          fail_count = 0, tests_run = 0, cyc = 0, n, w, h;
  row_type     r;
  // Periods are in ref_clk cycles: one input clock period is eight of them
  row_type     rows [6] = '{
    '{0, FN_RATE,      1'b0, 16'h0003, 8,  24, 1'b0},
    '{1, FN_SQUARE,    1'b0, 16'h0004, 16, 32, 1'b0},
    '{2, FN_RATE,      1'b0, 16'h0005, 8,  40, 1'b0},
    '{0, FN_RATE,      1'b1, 16'h0012, 8,  96, 1'b0},
    '{0, FN_SW_STROBE, 1'b0, 16'h0003, 8,  0,  1'b0},
    '{1, FN_HW_STROBE, 1'b0, 16'h0002, 8,  0,  1'b1}
  };

  interval_timer uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_func(cfg_func),
    .cfg_bcd(cfg_bcd), .load_we(load_we), .load_sel(load_sel), .load_value(load_value),
    .latch_req(latch_req), .latch_sel(latch_sel), .sw_trigger(sw_trigger), .trig_sel(trig_sel),
    .cnt_clk_pin(cnt_clk_pin), .event_pin(event_pin), .gate_pin(gate_pin), .gate_pp(gate_pp),
    .gate_src_sel(gate_src_sel), .route_irq_en(route_irq_en), .route_drv_en(route_drv_en),
    .route_ppin_en(route_ppin_en), .count_now(count_now), .latched_value(latched_value),
    .latched_valid(latched_valid), .timer_out(timer_out), .irq_req(irq_req), .pp_drive(pp_drive),
    .pp_in(pp_in), .baud_clk(baud_clk)
  );
  pin_model partner (
    .ref_clk(ref_clk), .run(run), .evt_go(evt_go), .clk_pins(cnt_clk_pin), .evt_pins(event_pin)
  );

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic start(input int ch, input func_type fn, input logic bcd, input logic [15:0] v);
    @(negedge ref_clk);
    cfg_we   = 1'b1;
    cfg_sel  = 2'(ch);
    cfg_func = fn;
    cfg_bcd  = bcd;
    @(negedge ref_clk);
    cfg_we     = 1'b0;
    load_we    = 1'b1;
    load_sel   = 2'(ch);
    load_value = v;
    @(negedge ref_clk);
    load_we = 1'b0;
  endtask : start

  task automatic wait_lvl(input int ch, input logic lvl, input int lim, output int k);
    k = 0;
    while (timer_out[ch] !== lvl && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : wait_lvl

  task automatic fire_evt(input int ch);
    @(negedge ref_clk);
    evt_go = 3'(1 << ch);
    @(negedge ref_clk);
    evt_go = 3'h0;
    repeat (10) @(negedge ref_clk);
  endtask : fire_evt

  task automatic fire_trig;
    @(negedge ref_clk);
    sw_trigger = 1'b1;
    @(negedge ref_clk);
    sw_trigger = 1'b0;
  endtask : fire_trig

  // The whole run needs about 1200 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, cfg_we, cfg_bcd, load_we, latch_req, sw_trigger, run, cfg_sel, load_sel, latch_sel} = '0;
    {gate_pp, gate_src_sel, route_irq_en, route_drv_en, route_ppin_en, cfg_func, evt_go, load_value} = '0;
    gate_pin = 2'h3;
    trig_sel = 2'h1;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(timer_out === 3'h7 && baud_clk === 1'b1 && count_now === 48'h0, "reset outputs");
    check(irq_req === 2'h0 && latched_valid === 1'b0, "reset flags");
    start(0, FN_TC_IRQ, 1'b0, 16'h0100);
    check(count_now[15:0] === 16'h0100, "live count");
    @(negedge ref_clk);
    latch_req = 1'b1;
    @(negedge ref_clk);
    latch_req = 1'b0;
    n = 0;
    while (latched_valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    check(n < 4 && latched_value === 16'h0100, "latched count");
    check(count_now[15:0] === 16'h0100, "count disturbed");
    start(1, FN_EVENT, 1'b0, 16'h0003);
    check(timer_out[1] === 1'b0, "event start");
    fire_evt(1);
    check(count_now[31:16] === 16'h0002, "event count");
    fire_evt(1);
    fire_evt(1);
    check(timer_out[1] === 1'b1, "event terminal");
    route_irq_en  = 2'h1;
    route_drv_en  = 2'h1;
    route_ppin_en = 2'h2;
    run           = 1'b1;
    start(0, FN_TC_IRQ, 1'b0, 16'h0002);
    check(timer_out[0] === 1'b0, "tc start");
    wait_lvl(0, 1'b1, 60, n);
    check(n < 60, "tc end");
    repeat (2) @(negedge ref_clk);
    check(irq_req === 2'h1 && pp_drive === 2'h1 && pp_in === 2'h2, "routing");
    repeat (20) @(negedge ref_clk);
    check(count_now[15:0] === 16'h0000 && timer_out[0] === 1'b1, "tc stop");
    start(1, FN_ONE_SHOT, 1'b0, 16'h0004);
    repeat (40) @(negedge ref_clk);
    check(timer_out[1] === 1'b1, "shot idle");
    fire_trig();
    check(timer_out[1] === 1'b0, "shot start");
    repeat (18) @(negedge ref_clk);
    fire_trig();
    repeat (20) @(negedge ref_clk);
    check(timer_out[1] === 1'b0, "retrigger");
    wait_lvl(1, 1'b1, 40, n);
    check(n < 40, "shot end");
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      if (r.trig) begin
        gate_pin[r.ch] = 1'b0;
      end
      start(r.ch, r.fn, r.bcd, r.n);
      if (r.trig) begin
        repeat (8) @(negedge ref_clk);
        gate_pin[r.ch] = 1'b1;
      end
      wait_lvl(r.ch, 1'b0, 400, n);
      wait_lvl(r.ch, 1'b1, 400, w);
      wait_lvl(r.ch, 1'b0, (r.per > 0) ? 400 : 200, h);
      check(n < 400 && w == r.low && (r.per > 0 ? w + h == r.per : h == 200), "row pattern");
    end
    wait_lvl(2, 1'b1, 60, n);
    wait_lvl(2, 1'b0, 60, n);
    @(negedge ref_clk);
    check(baud_clk === 1'b0, "baud follow");
    gate_src_sel = 2'h1;
    start(0, FN_RATE, 1'b0, 16'h0003);
    wait_lvl(0, 1'b0, 100, n);
    check(n == 100, "gate held");
    gate_pp = 2'h1;
    wait_lvl(0, 1'b0, 100, n);
    check(n < 100, "gate open");
    rst_n = 1'b0;
    @(negedge ref_clk);
    check(timer_out === 3'h7 && count_now === 48'h0 && baud_clk === 1'b1, "mid-run reset");
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(count_now === 48'h0 && latched_valid === 1'b0, "after reset");
    check(irq_req === 2'h1 && pp_in === 2'h2, "routing after reset");
    close_out();
  end
endmodule : interval_timer_event_counter_test
`default_nettype wire
